/* common/sckg_pkg.sv */
/*
 * sckg_pkg: constants, enumerations and carriers shared by the system clock
 * generator and its divider.
 * assumes: one source clock (mclk) that all logic runs on; counts are in
 * source clock cycles unless the name says watchdog.
 */
package sckg_pkg;

	// register map
	localparam logic [7:0] CDC_OFFSET      = 8'h00;
	localparam logic [7:0] STATUS_OFFSET   = 8'h01;
	localparam logic [7:0] CDC_RESET       = 8'h00;
	localparam int         DIV_EN_BIT      = 7;
	localparam int         DIV_SEL_W       = 7;
	localparam logic [7:0] DIV_BASE        = 8'h81;

	// fuse values as delivered
	localparam logic [3:0] FUSE_SRC_DEFAULT = 4'h1;
	localparam logic [1:0] FUSE_SUT_DEFAULT = 2'h2;
	// fuse field boundaries
	localparam logic [3:0] SRC_XTAL_LOW    = 4'hA;
	localparam logic [3:0] SRC_LOWFREQ     = 4'h9;
	localparam logic [3:0] SRC_EXTRC_LOW   = 4'h5;
	localparam logic [3:0] SRC_EXTCLK      = 4'h0;

	// start-up counts
	localparam int         WDT_SHORT_CYCLES = 4096;
	localparam int         WDT_LONG_CYCLES  = 65536;
	localparam int         SRC_258_CYCLES   = 258;
	localparam int         SRC_1K_CYCLES    = 1024;
	localparam int         SRC_16K_CYCLES   = 16384;
	localparam int         SRC_32K_CYCLES   = 32768;
	localparam int         SRC_OTHER_CYCLES = 6;
	localparam int         CNT_W            = 17;

	typedef enum logic [2:0] {
		SCKG_SRC_XTAL    = 3'h0,
		SCKG_SRC_LOWFREQ = 3'h1,
		SCKG_SRC_EXTRC   = 3'h2,
		SCKG_SRC_INTRC   = 3'h3,
		SCKG_SRC_EXTCLK  = 3'h4
	} sckg_src_t;

	typedef enum logic [2:0] {
		SCKG_SLP_IDLE     = 3'h0,
		SCKG_SLP_ADC_NR   = 3'h1,
		SCKG_SLP_PWR_DOWN = 3'h2,
		SCKG_SLP_PWR_SAVE = 3'h3,
		SCKG_SLP_STANDBY  = 3'h6,
		SCKG_SLP_EXT_STBY = 3'h7
	} sckg_sleep_t;

	typedef enum logic [1:0] {
		SCKG_ST_RST_DLY = 2'h0,
		SCKG_ST_SRC_DLY = 2'h1,
		SCKG_ST_RUN     = 2'h2,
		SCKG_ST_SLEEP   = 2'h3
	} sckg_fsm_t;

	// software register port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sckg_bus_t;

	// per-domain clock enables
	typedef struct packed {
		logic core_clock;
		logic peripheral_clock;
		logic program_memory_clock;
		logic async_timer_clock;
		logic converter_clock;
		logic twi_async_match;
		logic extint_async_detect;
	} sckg_gate_t;

endpackage : sckg_pkg

/* hw/sckg_divider.sv */
/*
 * sckg_divider: turns the source clock into a one-cycle tick every
 * (129 - division_select) cycles, or every cycle when division is off.
 * assumes: enable and select change only between ticks or the period in
 * progress ends early or runs to the new length, then restarts cleanly.
 */
module sckg_divider #(
	parameter int SEL_W = 7
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// control
	input  wire logic             divide_enable,
	input  wire logic [SEL_W-1:0] division_select,
	// output
	output logic                  div_tick
);
	import sckg_pkg::*;

	if (SEL_W != DIV_SEL_W) begin : g_chk
		$error("sckg_divider: SEL_W must equal the division select width");
	end

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} sckg_div_state_t;

	sckg_div_state_t s_reg;
	sckg_div_state_t s_next;
	logic [7:0]      last;

	always_comb begin
		s_next = s_reg;
		last   = DIV_BASE - 8'(division_select) - 8'h01;
		if (!divide_enable) begin
			s_next.cnt  = 8'h00;
			s_next.tick = 1'b1;
		end else if (s_reg.cnt >= last) begin
			s_next.cnt  = 8'h00;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt  = s_reg.cnt + 8'h01;
			s_next.tick = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign div_tick = s_reg.tick;

endmodule : sckg_divider

/* hw/sckg_top.sv */
/*
 * sckg_top: system clock generator. Decodes the clock source fuses, times
 * start-up after reset and after deep sleep, gates the clock domains per
 * sleep state and scales all but the async timer clock through a software divider.
 * assumes: mclk is the selected source clock; wdt_osc_tick and asy_xtal_tick
 * are one-cycle pulses already synchronous to mclk; fuse inputs are stable
 * around reset release; the register port follows a one-cycle strobe protocol.
 */
// Function
// RULE_01 - separately gated clock domains per sleep state
// RULE_02 - stopping core clock freezes core state
// RULE_03 - peripheral clock; async external interrupt detection stays
// RULE_04 - two-wire address match async when peripheral halted
// RULE_05 - program memory clock gated with core
// RULE_06 - async timer clock from crystal, runs in sleep
// RULE_07 - converter clock runs with core, peripheral stopped
// RULE_08 - enable bit divides core, peripheral, converter, memory
// RULE_09 - output equals source over 129 minus value
// RULE_10 - value writable only while disabled; enable captures
// RULE_11 - clearing enable discards written value
// RULE_12 - software keeps timer0 async, slow when divided
// RULE_13 - four-bit fuse field selects clock source
// RULE_14 - fuse one unprogrammed, zero programmed
// RULE_15 - deep-sleep wake waits source cycles first
// RULE_16 - reset adds 4K or 64K watchdog cycles
// RULE_17 - delivered fuses 0001 and 10
// RULE_18 - fuses sampled at reset, held afterwards
module sckg_top #(
	parameter int WDT_SHORT = sckg_pkg::WDT_SHORT_CYCLES,
	parameter int WDT_LONG  = sckg_pkg::WDT_LONG_CYCLES,
	parameter int SRC_16K   = sckg_pkg::SRC_16K_CYCLES,
	parameter int SRC_32K   = sckg_pkg::SRC_32K_CYCLES
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// register port
	input  wire sckg_pkg::sckg_bus_t   bus,
	output logic [7:0]                 rdata,
	// fuses
	input  wire logic [3:0]            fuse_clock_source_select,
	input  wire logic [1:0]            fuse_startup_time_select,
	// timing references
	input  wire logic                  wdt_osc_tick,
	input  wire logic                  asy_xtal_tick,
	// sleep control
	input  wire logic                  sleep_req,
	input  wire sckg_pkg::sckg_sleep_t sleep_mode,
	input  wire logic                  wake,
	// clock domain enables
	output sckg_pkg::sckg_gate_t       gates,
	// status
	output sckg_pkg::sckg_src_t        clock_source,
	output logic                       cpu_running,
	output logic                       div_active
);
	import sckg_pkg::*;

	// every start-up count must fit the shared down counter
	localparam int CNT_MAX = (1 << CNT_W) - 1;

	if (WDT_SHORT < 1 || WDT_LONG < WDT_SHORT || WDT_LONG > CNT_MAX) begin : g_chk_wdt
		$error("sckg_top: watchdog start-up counts out of range for the counter");
	end
	if (SRC_16K < 1 || SRC_32K < 1 || SRC_16K > CNT_MAX || SRC_32K > CNT_MAX) begin : g_chk_src
		$error("sckg_top: source start-up counts out of range for the counter");
	end
	// the divider base must sit one above the number of select values
	if (int'(DIV_BASE) != (1 << DIV_SEL_W) + 1) begin : g_chk_div
		$error("sckg_top: divider base does not match the select width");
	end

	typedef struct packed {
		sckg_fsm_t        fsm;
		logic [CNT_W-1:0] cnt;
		sckg_sleep_t      mode;
		logic             div_en;
		logic [6:0]       div_sel;
		logic [3:0]       fuse_src;
		logic [1:0]       fuse_sut;
		logic             fuses_taken;
		logic [7:0]       rdata;
		sckg_gate_t       gates;
		sckg_src_t        src;
		logic             running;
	} sckg_state_t;

	sckg_state_t s_reg;
	sckg_state_t s_next;
	logic        div_tick;

	// RULE_09 divide by 129 minus value
	sckg_divider #(
		.SEL_W           (DIV_SEL_W)
	) sckg_divider_inst (
		.mclk            (mclk),
		.nrst            (nrst),
		.divide_enable   (s_reg.div_en),
		.division_select (s_reg.div_sel),
		.div_tick        (div_tick)
	);

	// RULE_13 source decode from fuse field
	function automatic sckg_src_t decode_src(input logic [3:0] f);
		sckg_src_t r;
		// RULE_14 raw values, zero is programmed
		if (f >= SRC_XTAL_LOW) begin
			r = SCKG_SRC_XTAL;
		end else if (f == SRC_LOWFREQ) begin
			r = SCKG_SRC_LOWFREQ;
		end else if (f >= SRC_EXTRC_LOW) begin
			r = SCKG_SRC_EXTRC;
		end else if (f != SRC_EXTCLK) begin
			r = SCKG_SRC_INTRC;
		end else begin
			r = SCKG_SRC_EXTCLK;
		end
		return r;
	endfunction : decode_src

	// source cycles needed before execution
	function automatic logic [CNT_W-1:0] src_cycles(input sckg_src_t k, input logic ck0,
	                                                input logic [1:0] startup_time_select);
		logic [CNT_W-1:0] r;
		r = CNT_W'(SRC_OTHER_CYCLES);
		case (k)
			SCKG_SRC_XTAL: begin
				if (!ck0) begin
					r = startup_time_select[1] ? CNT_W'(SRC_1K_CYCLES) : CNT_W'(SRC_258_CYCLES);
				end else begin
					r = (startup_time_select == 2'h0) ? CNT_W'(SRC_1K_CYCLES) : CNT_W'(SRC_16K);
				end
			end
			SCKG_SRC_LOWFREQ: begin
				r = (startup_time_select == 2'h2) ? CNT_W'(SRC_32K) : CNT_W'(SRC_1K_CYCLES);
			end
			default: begin
				r = CNT_W'(SRC_OTHER_CYCLES);
			end
		endcase
		return r;
	endfunction : src_cycles

	// watchdog cycles added after reset, zero for none
	function automatic logic [CNT_W-1:0] wdt_cycles(input sckg_src_t k, input logic ck0,
	                                                input logic [1:0] startup_time_select);
		logic [CNT_W-1:0] r;
		logic [2:0]       code;
		code = {ck0, startup_time_select};
		r    = (startup_time_select == 2'h0) ? CNT_W'(WDT_SHORT) : CNT_W'(WDT_LONG);
		if (k == SCKG_SRC_XTAL) begin
			case (code)
				3'h0, 3'h3, 3'h6: begin
					r = CNT_W'(WDT_SHORT);
				end
				3'h2, 3'h5: begin
					r = '0;
				end
				default: begin
					r = CNT_W'(WDT_LONG);
				end
			endcase
		end
		return r;
	endfunction : wdt_cycles

	// per sleep state domain enables, before division
	function automatic sckg_gate_t domain_gates(input logic run, input logic asleep,
	                                            input sckg_sleep_t m);
		sckg_gate_t g;
		g = '0;
		// start-up delays leave every clocked domain off
		if (run) begin
			g.core_clock           = 1'b1;
			g.peripheral_clock     = 1'b1;
			g.program_memory_clock = 1'b1;
			g.async_timer_clock    = 1'b1;
			g.converter_clock      = 1'b1;
		end else if (asleep) begin
			case (m)
				SCKG_SLP_IDLE: begin
					g.peripheral_clock  = 1'b1;
					g.async_timer_clock = 1'b1;
					g.converter_clock   = 1'b1;
				end
				// RULE_07 converter and async timer keep running
				SCKG_SLP_ADC_NR: begin
					g.async_timer_clock = 1'b1;
					g.converter_clock   = 1'b1;
				end
				// RULE_06 async timer survives sleep
				SCKG_SLP_PWR_SAVE, SCKG_SLP_EXT_STBY: begin
					g.async_timer_clock = 1'b1;
				end
				default: begin
					g = '0;
				end
			endcase
		end
		// RULE_03 async interrupt detection when peripheral halted
		g.extint_async_detect = !g.peripheral_clock;
		// RULE_04 async address match when peripheral halted
		g.twi_async_match     = !g.peripheral_clock;
		return g;
	endfunction : domain_gates

	always_comb begin
		sckg_gate_t g;
		sckg_src_t  k;
		g      = '0;
		s_next = s_reg;
		k      = decode_src(s_reg.fuse_src);

		// RULE_18 sample fuses once after release
		if (!s_reg.fuses_taken) begin
			s_next.fuse_src    = fuse_clock_source_select;
			s_next.fuse_sut    = fuse_startup_time_select;
			s_next.fuses_taken = 1'b1;
			s_next.src         = decode_src(fuse_clock_source_select);
			s_next.cnt         = wdt_cycles(decode_src(fuse_clock_source_select),
			                                fuse_clock_source_select[0], fuse_startup_time_select);
		end else begin
			s_next.src = k;
			case (s_reg.fsm)
				// RULE_16 watchdog delay after reset
				SCKG_ST_RST_DLY: begin
					// a zero count (no extra delay) moves on at once
					if (s_reg.cnt == '0) begin
						s_next.fsm = SCKG_ST_SRC_DLY;
						s_next.cnt = src_cycles(k, s_reg.fuse_src[0], s_reg.fuse_sut);
					end else if (wdt_osc_tick) begin
						s_next.cnt = s_reg.cnt - CNT_W'(1);
					end
				end
				// RULE_15 count source cycles before execution
				SCKG_ST_SRC_DLY: begin
					if (s_reg.cnt <= CNT_W'(1)) begin
						s_next.fsm = SCKG_ST_RUN;
						s_next.cnt = '0;
					end else begin
						s_next.cnt = s_reg.cnt - CNT_W'(1);
					end
				end
				SCKG_ST_RUN: begin
					if (sleep_req) begin
						s_next.fsm  = SCKG_ST_SLEEP;
						s_next.mode = sleep_mode;
					end
				end
				SCKG_ST_SLEEP: begin
					if (wake) begin
						// RULE_15 deep sleep restarts oscillator timing
						if (s_reg.mode == SCKG_SLP_PWR_DOWN || s_reg.mode == SCKG_SLP_PWR_SAVE) begin
							s_next.fsm = SCKG_ST_SRC_DLY;
							s_next.cnt = src_cycles(k, s_reg.fuse_src[0], s_reg.fuse_sut);
						end else begin
							s_next.fsm = SCKG_ST_RUN;
						end
					end
				end
				default: begin
					s_next.fsm = SCKG_ST_RST_DLY;
				end
			endcase
		end

		// register writes
		if (bus.wr && bus.addr == CDC_OFFSET) begin
			if (bus.wdata[DIV_EN_BIT]) begin
				// an enabling write while enabled keeps the active factor
				// RULE_10 capture value on enabling write
				if (!s_reg.div_en) begin
					s_next.div_sel = bus.wdata[DIV_SEL_W-1:0];
				end
				s_next.div_en = 1'b1;
			end else begin
				// RULE_11 value discarded on disabling write
				s_next.div_en = 1'b0;
			end
		end

		// register reads, data in the following cycle
		s_next.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				CDC_OFFSET: begin
					s_next.rdata = {s_reg.div_en, s_reg.div_sel};
				end
				// zero, source, idle mode, running, state
				STATUS_OFFSET: begin
					s_next.rdata = {1'b0, s_reg.src, s_reg.mode == SCKG_SLP_IDLE, s_reg.running, s_reg.fsm};
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end

		// RULE_01 domain enables from state and sleep mode
		g = domain_gates(s_reg.fuses_taken && s_reg.fsm == SCKG_ST_RUN,
		                 s_reg.fsm == SCKG_ST_SLEEP, s_reg.mode);
		// enables are registered so each one leaves a flip-flop
		// RULE_08 divided domains follow the divider tick
		s_next.gates.peripheral_clock     = g.peripheral_clock && div_tick;
		s_next.gates.converter_clock      = g.converter_clock && div_tick;
		// RULE_02 core halts outside run
		s_next.gates.core_clock           = g.core_clock && div_tick;
		// RULE_05 program memory follows core
		s_next.gates.program_memory_clock = g.core_clock && div_tick;
		// RULE_06 undivided crystal tick
		s_next.gates.async_timer_clock    = g.async_timer_clock && asy_xtal_tick;
		s_next.gates.twi_async_match      = g.twi_async_match;
		s_next.gates.extint_async_detect  = g.extint_async_detect;
		// undivided: a slowly divided core still reads as running
		s_next.running                    = g.core_clock;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_reg.fsm         <= SCKG_ST_RST_DLY;
			s_reg.cnt         <= '0;
			s_reg.mode        <= SCKG_SLP_IDLE;
			s_reg.div_en      <= CDC_RESET[DIV_EN_BIT];
			s_reg.div_sel     <= CDC_RESET[DIV_SEL_W-1:0];
			// RULE_17 delivered fuse values until sampled
			s_reg.fuse_src    <= FUSE_SRC_DEFAULT;
			s_reg.fuse_sut    <= FUSE_SUT_DEFAULT;
			s_reg.fuses_taken <= 1'b0;
			s_reg.rdata       <= 8'h00;
			s_reg.gates       <= '0;
			s_reg.src         <= SCKG_SRC_INTRC;
			s_reg.running     <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata        = s_reg.rdata;
	assign gates        = s_reg.gates;
	assign clock_source = s_reg.src;
	assign cpu_running  = s_reg.running;
	assign div_active   = s_reg.div_en;

endmodule : sckg_top

/* test/sckg_core_model.sv */
/*
 * sckg_core_model: stand-in for the clocked core and the async timer.
 * assumes: gates from sckg_top, all on mclk.
 */
module sckg_core_model (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// domain enables
	input  wire sckg_pkg::sckg_gate_t gates,
	// state seen by the bench
	output logic [15:0]               core_cnt,
	output logic [15:0]               asy_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	import sckg_pkg::*;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			core_cnt <= 16'h0000;
			asy_cnt  <= 16'h0000;
		end else begin
			if (gates.core_clock)
				core_cnt <= core_cnt + 16'h0001;
			// timer runs from async clock only
			if (gates.async_timer_clock)
				asy_cnt <= asy_cnt + 16'h0001;
		end
	end
endmodule : sckg_core_model

/* test/sckg_top_chk.sv */
/*
 * sckg_top_chk: port properties of the clock generator.
 * assumes: bound into sckg_top; one clock, nrst active low.
 */
module sckg_top_chk (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// register port
	input  wire sckg_pkg::sckg_bus_t  bus,
	input  wire logic [7:0]           rdata,
	// references and outputs
	input  wire logic                 asy_xtal_tick,
	input  wire sckg_pkg::sckg_gate_t gates,
	input  wire sckg_pkg::sckg_src_t  clock_source,
	input  wire logic                 div_active
);
	timeunit 1ns;
	timeprecision 1ns;
	import sckg_pkg::*;
	logic [1:0] age_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end
	property p_mem; gates.program_memory_clock == gates.core_clock; endproperty
	a_mem: assert property (p_mem) else $error("memory clock apart from core");
	property p_all; gates.core_clock |-> gates.peripheral_clock && gates.converter_clock; endproperty
	a_all: assert property (p_all) else $error("domains not divided together");
	property p_div; $past(div_active) && div_active && gates.core_clock |=> !gates.core_clock; endproperty
	a_div: assert property (p_div) else $error("divided tick too close");
	property p_run; gates.core_clock |-> !gates.twi_async_match && !gates.extint_async_detect; endproperty
	a_run: assert property (p_run) else $error("async detect armed while running");
	property p_pair; gates.twi_async_match == gates.extint_async_detect; endproperty
	a_pair: assert property (p_pair) else $error("async detectors disagree");
	property p_asy; gates.async_timer_clock |-> $past(asy_xtal_tick); endproperty
	a_asy: assert property (p_asy) else $error("timer tick without crystal tick");
	property p_rd; bus.rd && bus.addr == CDC_OFFSET |=> rdata[7] == div_active; endproperty
	a_rd: assert property (p_rd) else $error("read enable bit mismatch");
	property p_idle; !bus.rd |=> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read cycle");
	property p_unm; bus.rd && bus.addr > STATUS_OFFSET |=> rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_hold; age_reg == 2'h3 |-> $stable(clock_source); endproperty
	a_hold: assert property (p_hold) else $error("source changed while running");
	c_div: cover property (div_active && gates.core_clock);
	c_slp: cover property (gates.twi_async_match);
	c_rd: cover property (rdata != 8'h00);
endmodule : sckg_top_chk
bind sckg_top sckg_top_chk sckg_top_chk_inst (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
	.asy_xtal_tick(asy_xtal_tick), .gates(gates), .clock_source(clock_source), .div_active(div_active));

/* test/sckg_top_test.sv */
/*
 * sckg_top_test: self-checking bench for sckg_top.
 * assumes: short start-up parameters; reference ticks made here.
 */
module sckg_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sckg_pkg::*;
	logic        mclk, nrst, wdt_osc_tick, asy_xtal_tick, sleep_req, wake, cpu_running, div_active;
	sckg_bus_t   bus;
	logic [7:0]  rdata, tick_cnt;
	logic [3:0]  fuse_src;
	logic [1:0]  fuse_sut;
	sckg_sleep_t sleep_mode;
	sckg_gate_t  gates;
	sckg_src_t   clock_source;
	logic [15:0] core_cnt, asy_cnt;
	int          errors, total_checks;

	sckg_top #(.WDT_SHORT(8), .WDT_LONG(16), .SRC_16K(10), .SRC_32K(12)) sckg_top_inst (.mclk(mclk),
		.nrst(nrst), .bus(bus), .rdata(rdata), .fuse_clock_source_select(fuse_src),
		.fuse_startup_time_select(fuse_sut), .wdt_osc_tick(wdt_osc_tick), .asy_xtal_tick(asy_xtal_tick),
		.sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake(wake), .gates(gates),
		.clock_source(clock_source), .cpu_running(cpu_running), .div_active(div_active));
	sckg_core_model sckg_core_model_inst (.mclk(mclk), .nrst(nrst), .gates(gates), .core_cnt(core_cnt),
		.asy_cnt(asy_cnt));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// watchdog pulse every 2 cycles, crystal every 4
	always @(posedge mclk) begin
		tick_cnt      <= tick_cnt + 8'h01;
		wdt_osc_tick  <= tick_cnt[0];
		asy_xtal_tick <= (tick_cnt[1:0] == 2'h0);
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rd_chk

	task wait_core(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (gates.core_clock !== 1'b1 && n < 400);
	endtask : wait_core

	task do_reset(input logic [3:0] src, input logic [1:0] startup_time_select);
		@(posedge mclk);
		nrst     <= 1'b0;
		fuse_src <= src;
		fuse_sut <= startup_time_select;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
	endtask : do_reset

	task t_startup(input logic [3:0] src, input logic [1:0] startup_time_select, input sckg_src_t exp,
	               input int lo, input int hi);
		int n;
		do_reset(src, startup_time_select);
		#1 chk(clock_source, SCKG_SRC_INTRC);
		wait_core(n);
		chk(n >= lo && n <= hi, 1'b1);
		chk(clock_source, exp);
		chk(cpu_running, 1'b1);
	endtask : t_startup

	task t_reg();
		logic [7:0] d;
		rd_chk(CDC_OFFSET, CDC_RESET);
		rd_chk(8'h40, 8'h00);
		rd(STATUS_OFFSET, d);
		chk({d[6:4], d[1:0]}, {SCKG_SRC_INTRC, 2'h2});
		wr(CDC_OFFSET, 8'h85);
		rd_chk(CDC_OFFSET, 8'h85);
		chk(div_active, 1'b1);
		wr(CDC_OFFSET, 8'h93);
		rd_chk(CDC_OFFSET, 8'h85);
		wr(CDC_OFFSET, 8'h33);
		rd_chk(CDC_OFFSET, 8'h05);
		chk(div_active, 1'b0);
	endtask : t_reg

	task t_sleep(input sckg_sleep_t m, input logic [2:0] e);
		logic [15:0] c0, a0;
		logic [2:0]  acc;
		int          n;
		@(posedge mclk);
		sleep_mode <= m;
		sleep_req  <= 1'b1;
		@(posedge mclk);
		sleep_req <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 c0 = core_cnt;
		a0  = asy_cnt;
		acc = 3'h0;
		repeat (12) begin
			@(posedge mclk);
			#1 acc = acc | {gates.peripheral_clock, gates.converter_clock, gates.twi_async_match};
		end
		chk(acc, {e[2:1], !e[2]});
		chk(core_cnt - c0, 16'h0000);
		chk(cpu_running, 1'b0);
		chk(asy_cnt != a0, e[0]);
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		wait_core(n);
		chk(m inside {SCKG_SLP_PWR_DOWN, SCKG_SLP_PWR_SAVE} ? n >= 5 && n <= 9 : n <= 2, 1'b1);
	endtask : t_sleep

	task t_div(input logic [6:0] d);
		int n;
		wr(CDC_OFFSET, {1'b1, d});
		repeat (3) wait_core(n);
		chk(n, 32'h0000_0081 - 32'(d));
		wr(CDC_OFFSET, 8'h00);
	endtask : t_div

	task t_fuses(input logic [3:0] src, input sckg_src_t exp);
		do_reset(src, 2'h0);
		repeat (3) @(posedge mclk);
		fuse_src <= ~src;
		repeat (3) @(posedge mclk);
		#1 chk(clock_source, exp);
	endtask : t_fuses

	task tally_and_finish();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#2_000_000;
		errors++;
		tally_and_finish();
	end

	initial begin
		errors = 0;
		total_checks = 0;
		nrst = 1'b0;
		bus = '0;
		tick_cnt = 8'h00;
		wdt_osc_tick = 1'b0;
		asy_xtal_tick = 1'b0;
		sleep_req = 1'b0;
		wake = 1'b0;
		sleep_mode = SCKG_SLP_IDLE;
		fuse_src = FUSE_SRC_DEFAULT;
		fuse_sut = FUSE_SUT_DEFAULT;
		t_startup(FUSE_SRC_DEFAULT, FUSE_SUT_DEFAULT, SCKG_SRC_INTRC, 34, 48);
		t_reg();
		t_sleep(SCKG_SLP_IDLE, 3'b111);
		t_sleep(SCKG_SLP_ADC_NR, 3'b011);
		t_sleep(SCKG_SLP_PWR_SAVE, 3'b001);
		t_sleep(SCKG_SLP_PWR_DOWN, 3'b000);
		t_sleep(SCKG_SLP_STANDBY, 3'b000);
		t_sleep(SCKG_SLP_EXT_STBY, 3'b001);
		t_div(7'h05);
		t_div(7'h7F);
		t_div(7'h00);
		t_fuses(4'hF, SCKG_SRC_XTAL);
		t_fuses(4'hA, SCKG_SRC_XTAL);
		t_fuses(4'h9, SCKG_SRC_LOWFREQ);
		t_fuses(4'h8, SCKG_SRC_EXTRC);
		t_fuses(4'h5, SCKG_SRC_EXTRC);
		t_fuses(4'h4, SCKG_SRC_INTRC);
		t_fuses(4'h0, SCKG_SRC_EXTCLK);
		t_startup(FUSE_SRC_DEFAULT, 2'h0, SCKG_SRC_INTRC, 18, 32);
		t_startup(4'h9, 2'h2, SCKG_SRC_LOWFREQ, 44, 50);
		t_startup(4'hB, 2'h1, SCKG_SRC_XTAL, 12, 14);
		tally_and_finish();
	end
endmodule : sckg_top_test
